// >>> htc_top.sv
`timescale 1ns/1ps
module htc_top #(
	parameter int STARTUP_LEN = htc_pkg::STARTUP_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic supply_ok_i,
	input wire htc_pkg::htc_sample_t sample_i,
	input wire logic sample_vld_i,
	input wire logic [htc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [htc_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [htc_pkg::DATA_W-1:0] rdata_o,
	output logic [htc_pkg::CODE_W-1:0] sent_value_o,
	output logic output_valid_o,
	output logic startup_done_o,
	output logic pwm_o
);
	import htc_pkg::*;

	localparam logic [19:0] START_LAST = 20'(STARTUP_LEN - 1);

	// ****************************************
	// register file
	// ****************************************
	logic [WORD_W-1:0] second_order_sens_coeffs;
	logic [WORD_W-1:0] first_order_temp_coeffs;
	logic [WORD_W-1:0] control;
	logic [CODE_W-1:0] out_code;
	logic output_valid;
	htc_coeff_t coeff;
	logic mode_pwm;
	logic [CODE_W-1:0] zero_field_output;

	assign coeff = htc_decode(second_order_sens_coeffs, first_order_temp_coeffs);
	assign mode_pwm = control[CTRL_MODE_BIT];
	assign zero_field_output = control[CTRL_ZFO_LSB +: CODE_W];

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			second_order_sens_coeffs <= SECOND_ORDER_RST;
			first_order_temp_coeffs <= FIRST_ORDER_RST;
			control <= CONTROL_RST;
		end else if (ce_i && wr_i) begin
			unique case (addr_i)
				OFS_SECOND_ORDER: second_order_sens_coeffs <= wdata_i[WORD_W-1:0];
				OFS_FIRST_ORDER: first_order_temp_coeffs <= wdata_i[WORD_W-1:0];
				OFS_CONTROL: control <= wdata_i[WORD_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			if (rd_i) begin
				unique case (addr_i)
					OFS_SECOND_ORDER: rdata_o <= {8'h00, second_order_sens_coeffs};
					OFS_FIRST_ORDER: rdata_o <= {8'h00, first_order_temp_coeffs};
					OFS_CONTROL: rdata_o <= {8'h00, control};
					OFS_STATUS: rdata_o <= {4'h0, out_code, 14'h0000, output_valid, startup_done_o};
					default: rdata_o <= '0;
				endcase
			end else begin
				rdata_o <= '0;
			end
		end
	end

	// ****************************************
	// power-up sequencing
	// ****************************************
	logic supply_ok;
	htc_power_t power;
	logic [19:0] start_cnt;

	htc_sync2 u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i(supply_ok_i),
		.sync_o(supply_ok)
	);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			power <= ST_WAIT_SUPPLY;
			start_cnt <= 20'h00000;
		end else if (ce_i) begin
			if (!supply_ok) begin
				// supply dip restarts the whole startup wait
				power <= ST_WAIT_SUPPLY;
				start_cnt <= 20'h00000;
			end else begin
				unique case (power)
					ST_WAIT_SUPPLY: begin
						power <= ST_STARTING;
						start_cnt <= 20'h00000;
					end
					ST_STARTING: begin
						if (start_cnt == START_LAST) begin
							power <= ST_RUNNING;
						end else begin
							start_cnt <= start_cnt + 20'h00001;
						end
					end
					ST_RUNNING: ;
					default: power <= ST_WAIT_SUPPLY;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			startup_done_o <= 1'b0;
		end else if (ce_i) begin
			startup_done_o <= (power == ST_RUNNING) && supply_ok;
		end
	end

	// ****************************************
	// compensation pipeline
	// ****************************************
	logic [4:0] vld;
	logic signed [15:0] s1_field;
	logic signed [9:0] s1_dt;
	logic signed [7:0] s1_ofc;
	logic signed [15:0] s1_tc1;
	logic signed [18:0] s1_tc2;
	logic signed [20:0] s1_dt2;
	logic signed [15:0] s2_field;
	logic signed [19:0] s2_off;
	logic signed [35:0] s2_t1;
	logic signed [39:0] s2_t2;
	logic signed [20:0] s3_corr1;
	logic signed [39:0] s3_gain;
	logic signed [31:0] s4_corr2;
	logic [7:0] lin_sel;
	logic [8:0] quad_sel;
	logic dt_zero;
	logic signed [15:0] next_tc1;
	logic signed [18:0] next_tc2;
	logic [CODE_W-1:0] next_code;
	logic next_output_valid;

	always_comb begin
		dt_zero = (sample_i.temp_delta == 10'sd0);
		if (sample_i.temp_delta > 10'sd0) begin
			lin_sel = coeff.lin_sens_coeff_warm;
			quad_sel = coeff.quad_sens_coeff_warm;
		end else begin
			lin_sel = coeff.lin_sens_coeff_cold;
			quad_sel = coeff.quad_sens_coeff_cold;
		end
		// exactly 25 degC: leave the gain alone whatever the codes hold
		if (dt_zero) begin
			next_tc1 = '0;
			next_tc2 = '0;
		end else begin
			next_tc1 = 16'(TC1_BASE + TC1_STEP * int'(lin_sel));
			next_tc2 = 19'(TC2_BASE + TC2_STEP * int'(quad_sel));
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			vld <= 5'h00;
		end else if (ce_i) begin
			vld <= {vld[3:0], sample_vld_i};
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s1_field <= '0;
			s1_dt <= '0;
			s1_ofc <= '0;
			s1_tc1 <= '0;
			s1_tc2 <= '0;
			s1_dt2 <= '0;
		end else if (ce_i && sample_vld_i) begin
			s1_field <= sample_i.field;
			s1_dt <= sample_i.temp_delta;
			s1_ofc <= coeff.offset_drift_coeff;
			s1_tc1 <= next_tc1;
			s1_tc2 <= next_tc2;
			s1_dt2 <= 21'(int'(sample_i.temp_delta) * int'(sample_i.temp_delta));
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s2_field <= '0;
			s2_off <= '0;
			s2_t1 <= '0;
			s2_t2 <= '0;
		end else if (ce_i && vld[0]) begin
			s2_field <= s1_field;
			if (s1_ofc == 8'sd0) begin
				s2_off <= '0;
			end else begin
				// 968/256 mG per code per degC puts code 127 at 0.48 G/degC
				s2_off <= 20'((int'(s1_ofc) * int'(s1_dt) * OFFS_SCALE) >>> OFFS_SHIFT);
			end
			s2_t1 <= 36'(longint'(s1_tc1) * longint'(s1_dt) * TC1_FRAC);
			s2_t2 <= 40'(longint'(s1_tc2) * longint'(s1_dt2));
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s3_corr1 <= '0;
			s3_gain <= '0;
		end else if (ce_i && vld[1]) begin
			s3_corr1 <= 21'(int'(s2_field) - int'(s2_off));
			// terms are in 1e-10 of gain; 110/1024 maps them onto 2^30 as unity
			s3_gain <= 40'((longint'(1) <<< GAIN_ONE_SHIFT)
				+ (((longint'(s2_t1) + longint'(s2_t2)) * GAIN_K) >>> GAIN_KSHIFT));
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s4_corr2 <= '0;
		end else if (ce_i && vld[2]) begin
			s4_corr2 <= 32'((longint'(s3_corr1) * longint'(s3_gain)) >>> GAIN_ONE_SHIFT);
		end
	end

	always_comb begin
		next_code = htc_clamp_code((longint'(s4_corr2) >>> FIELD_SHIFT)
			+ longint'(zero_field_output) + (mode_pwm ? PWM_MID : 64'sd0));
	end

	// ****************************************
	// output side
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			out_code <= '0;
		end else if (ce_i && vld[3]) begin
			out_code <= next_code;
		end
	end

	// first result and its valid flag leave together, so no stale code leads it
	assign next_output_valid = (power == ST_RUNNING) && (output_valid || vld[4]);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			output_valid <= 1'b0;
		end else if (ce_i) begin
			output_valid <= next_output_valid;
		end
	end

	// frames sample the held value, so a slow update repeats it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sent_value_o <= '0;
			output_valid_o <= 1'b0;
		end else if (ce_i) begin
			output_valid_o <= next_output_valid && !mode_pwm;
			if (next_output_valid) begin
				sent_value_o <= out_code;
			end
		end
	end

	htc_pwm u_pwm (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.run_i(output_valid && mode_pwm),
		.code_i(out_code),
		.pwm_o(pwm_o)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	chk_read_first_word: assert property (ce_i && rd_i && addr_i == OFS_FIRST_ORDER
		|=> rdata_o == {8'h00, $past(first_order_temp_coeffs)})
		else $error("first-order word read back wrong");
	chk_offset_zero: assert property (ce_i && vld[0] && s1_ofc == 8'sd0 |=> s2_off == 20'sd0)
		else $error("offset correction applied with zero code");
	chk_warm_select: assert property (ce_i && sample_vld_i && sample_i.temp_delta > 10'sd0
		|=> s1_tc1 == 16'(TC1_BASE + TC1_STEP * int'($past(coeff.lin_sens_coeff_warm))))
		else $error("warm linear coefficient not selected");
	chk_cold_select: assert property (ce_i && sample_vld_i && sample_i.temp_delta < 10'sd0
		|=> s1_tc2 == 19'(TC2_BASE + TC2_STEP * int'($past(coeff.quad_sens_coeff_cold))))
		else $error("cold quadratic coefficient not selected");
	chk_zero_delta: assert property (ce_i && sample_vld_i && dt_zero
		|=> s1_tc1 == 16'sd0 && s1_tc2 == 19'sd0)
		else $error("sensitivity terms nonzero at 25 degC");
	chk_code_clamp: assert property (ce_i && vld[3] && s4_corr2 >= 32'sd65536
		|=> out_code == 12'hfff)
		else $error("large positive field not clamped to 4095");
	chk_quiescent: assert property (ce_i && vld[3] && s4_corr2 == 32'sd0 && mode_pwm
		&& zero_field_output == 12'h000 |=> out_code == 12'h800)
		else $error("pwm quiescent not at half scale");
	chk_startup_len: assert property ($rose(power == ST_RUNNING)
		|-> $past(start_cnt) == START_LAST)
		else $error("startup wait has wrong length");
	chk_withheld: assert property (power != ST_RUNNING |-> ##2 !output_valid_o && !pwm_o)
		else $error("output driven before startup ended");
	cov_startup: cover property (power == ST_STARTING ##1 power == ST_RUNNING);
	cov_first_valid: cover property ($rose(output_valid));
	cov_clamp_low: cover property (vld[3] && next_code == 12'h000 && s4_corr2 < 32'sd0);
endmodule

// >>> htc_pkg.sv
// Behaviour
// - offset drift coefficient is signed 8-bit, bits 7:0 of word 0x09
// - offset drift code scales so +127 gives +0.48 G/degC, -128 gives -0.48
// - zero offset drift code applies no temperature offset correction
// - linear sensitivity term uses warm coefficient above 25 degC, cold below
// - linear code 0 is -98, all ones +292 m%/degC, step 1.53
// - word 0x09 holds cold linear code in 15:8, warm in 23:16
// - quadratic sensitivity term uses warm coefficient above 25 degC, cold below
// - word 0x08 holds cold quadratic code in 14:6, warm in 23:15
// - quadratic code spans -1.53 to +1.52 m%/degC, step 0.00596
// - pwm full scale runs from 5% to 95% duty
// - sent full scale is a 12-bit value 0 to 4095
// - zero field gives 0 lsb sent or 50% pwm, shifted by programming
// - output frames may repeat an old value until a new one is ready
// - output withheld after supply good until startup ends
package htc_pkg;
	localparam int CLK_MHZ = 40;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int WORD_W = 24;
	localparam int CODE_W = 12;
	localparam logic [ADDR_W-1:0] OFS_SECOND_ORDER = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_FIRST_ORDER = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'ha;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hb;
	localparam logic [WORD_W-1:0] SECOND_ORDER_RST = 24'h000000;
	localparam logic [WORD_W-1:0] FIRST_ORDER_RST = 24'h000000;
	localparam logic [WORD_W-1:0] CONTROL_RST = 24'h000000;
	localparam int OFF_DRIFT_LSB = 0;
	localparam int LIN_COLD_LSB = 8;
	localparam int LIN_WARM_LSB = 16;
	localparam int QUAD_COLD_LSB = 6;
	localparam int QUAD_WARM_LSB = 15;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_ZFO_LSB = 4;
	localparam int STAT_CODE_LSB = 16;
	// fixed-point scaling of the coefficient codes
	localparam int OFFS_SCALE = 968;
	localparam int OFFS_SHIFT = 8;
	localparam int TC1_BASE = -9800;
	localparam int TC1_STEP = 153;
	localparam longint TC1_FRAC = 1000;
	localparam int TC2_BASE = -153000;
	localparam int TC2_STEP = 596;
	localparam longint GAIN_K = 110;
	localparam int GAIN_KSHIFT = 10;
	localparam int GAIN_ONE_SHIFT = 30;
	localparam int FIELD_SHIFT = 4;
	localparam longint CODE_MAX = 4095;
	localparam longint PWM_MID = 2048;
	// timing
	localparam int STARTUP_TIME_US = 1000;
	localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLK_MHZ;
	localparam int PWM_PERIOD_US = 100;
	localparam int PWM_PERIOD_CYC = PWM_PERIOD_US * CLK_MHZ;
	localparam int PWM_LO_PCT = 5;
	localparam int PWM_HI_PCT = 95;
	localparam int PWM_LO_CYC = PWM_PERIOD_CYC * PWM_LO_PCT / 100;
	localparam int PWM_HI_CYC = PWM_PERIOD_CYC * PWM_HI_PCT / 100;
	localparam int PWM_SCALE = PWM_HI_CYC - PWM_LO_CYC + 1;

	typedef struct packed {
		logic signed [15:0] field;
		logic signed [9:0] temp_delta;
	} htc_sample_t;

	typedef struct packed {
		logic signed [7:0] offset_drift_coeff;
		logic [7:0] lin_sens_coeff_cold;
		logic [7:0] lin_sens_coeff_warm;
		logic [8:0] quad_sens_coeff_cold;
		logic [8:0] quad_sens_coeff_warm;
	} htc_coeff_t;

	typedef enum logic [1:0] {ST_WAIT_SUPPLY, ST_STARTING, ST_RUNNING} htc_power_t;

	function automatic htc_coeff_t htc_decode(input logic [WORD_W-1:0] second,
		input logic [WORD_W-1:0] first);
		htc_coeff_t c;
		c.offset_drift_coeff = first[OFF_DRIFT_LSB +: 8];
		c.lin_sens_coeff_cold = first[LIN_COLD_LSB +: 8];
		c.lin_sens_coeff_warm = first[LIN_WARM_LSB +: 8];
		c.quad_sens_coeff_cold = second[QUAD_COLD_LSB +: 9];
		c.quad_sens_coeff_warm = second[QUAD_WARM_LSB +: 9];
		return c;
	endfunction

	function automatic logic [CODE_W-1:0] htc_clamp_code(input longint v);
		if (v < 0) begin
			return 12'h000;
		end else if (v > CODE_MAX) begin
			return 12'hfff;
		end
		return v[CODE_W-1:0];
	endfunction
endpackage

// >>> htc_sync2.sv
`timescale 1ns/1ps
module htc_sync2 (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			sync_o <= 1'b0;
		end else if (ce_i) begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule

// >>> htc_pwm.sv
`timescale 1ns/1ps
module htc_pwm (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic run_i,
	input wire logic [htc_pkg::CODE_W-1:0] code_i,
	output logic pwm_o
);
	import htc_pkg::*;

	localparam logic [11:0] PERIOD_LAST = 12'(PWM_PERIOD_CYC - 1);
	localparam logic [11:0] HI_CYC = 12'(PWM_HI_CYC);
	logic [11:0] cnt;
	logic [11:0] duty;
	logic [11:0] next_duty;

	assign next_duty = 12'(PWM_LO_CYC + ((int'(code_i) * PWM_SCALE) >>> CODE_W));

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 12'h000;
			duty <= 12'h000;
		end else if (ce_i) begin
			if (!run_i || cnt == PERIOD_LAST) begin
				cnt <= 12'h000;
				// new duty only at a period boundary or while stopped, so a period may repeat
				duty <= next_duty;
			end else begin
				cnt <= cnt + 12'h001;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_o <= 1'b0;
		end else if (ce_i) begin
			pwm_o <= run_i && (cnt < duty);
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	chk_pwm_low_bound: assert property (ce_i && run_i && cnt == 12'h000 |=> pwm_o)
		else $error("pwm low at start of period");
	chk_pwm_high_bound: assert property (ce_i && cnt >= HI_CYC |=> !pwm_o)
		else $error("pwm high past 95 percent");
	chk_duty_hold: assert property (ce_i && run_i && cnt != PERIOD_LAST |=> $stable(duty))
		else $error("duty changed inside a period");
	cov_pwm_period: cover property (run_i && cnt == PERIOD_LAST ##1 run_i);
endmodule

// >>> htc_dummy_unused_guard.sv
`timescale 1ns/1ps

// >>> htc_pwm_rx.sv
`timescale 1ns/1ps
// ****
// far-side receiver: measures pwm period and high time
// ****
module htc_pwm_rx (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic pwm_i,
	output logic [15:0] period_o,
	output logic [15:0] high_o,
	output logic [7:0] count_o
);
	logic prev;
	logic [15:0] cnt;
	logic [15:0] hcnt;

	// a period is closed at each rising edge, so the first report is partial
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			prev <= 1'b0;
			cnt <= 16'h0000;
			hcnt <= 16'h0000;
			period_o <= 16'h0000;
			high_o <= 16'h0000;
			count_o <= 8'h00;
		end else begin
			prev <= pwm_i;
			if (pwm_i && !prev) begin
				period_o <= cnt;
				high_o <= hcnt;
				count_o <= count_o + 8'h01;
				cnt <= 16'h0001;
				hcnt <= 16'h0001;
			end else begin
				cnt <= cnt + 16'h0001;
				hcnt <= hcnt + 16'(pwm_i);
			end
		end
	end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
	import htc_pkg::*;
	logic clk_sys_i;
	logic rst_i;
	logic ce_i;
	logic supply_ok_i;
	htc_sample_t sample_i;
	logic sample_vld_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [DATA_W-1:0] rdata_o;
	logic [CODE_W-1:0] sent_value_o;
	logic output_valid_o;
	logic startup_done_o;
	logic pwm_o;
	logic [15:0] rx_period;
	logic [15:0] rx_high;
	logic [7:0] rx_count;
	logic [23:0] w8;
	logic [23:0] w9;
	logic [23:0] w10;
	logic [11:0] pipe [6];
	logic [5:0] pipe_v = '0;
	logic chk_on = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;

	htc_top #(.STARTUP_LEN(16)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
		.supply_ok_i(supply_ok_i), .sample_i(sample_i), .sample_vld_i(sample_vld_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.sent_value_o(sent_value_o), .output_valid_o(output_valid_o),
		.startup_done_o(startup_done_o), .pwm_o(pwm_o));
	htc_pwm_rx rx (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pwm_i(pwm_o), .period_o(rx_period),
		.high_o(rx_high), .count_o(rx_count));

	// ****
	// reference arithmetic
	// ****
	function automatic logic [11:0] exp_code(input htc_sample_t s);
		longint dt;
		longint ofs;
		longint tc1;
		longint tc2;
		longint off;
		longint gain;
		longint c;
		dt = s.temp_delta;
		ofs = $signed(w9[7:0]);
		tc1 = 0;
		tc2 = 0;
		if (dt > 0) begin
			tc1 = TC1_BASE + TC1_STEP * longint'(w9[23:16]);
			tc2 = TC2_BASE + TC2_STEP * longint'(w8[23:15]);
		end else if (dt < 0) begin
			tc1 = TC1_BASE + TC1_STEP * longint'(w9[15:8]);
			tc2 = TC2_BASE + TC2_STEP * longint'(w8[14:6]);
		end
		off = (ofs * dt * OFFS_SCALE) >>> OFFS_SHIFT;
		gain = ((tc1 * dt * TC1_FRAC + tc2 * dt * dt) * GAIN_K) >>> GAIN_KSHIFT;
		gain = gain + (longint'(1) <<< GAIN_ONE_SHIFT);
		c = ((longint'(s.field) - off) * gain) >>> GAIN_ONE_SHIFT;
		c = (c >>> FIELD_SHIFT) + longint'(w10[15:4]) + (w10[0] ? PWM_MID : 0);
		if (c < 0) begin
			c = 0;
		end else if (c > CODE_MAX) begin
			c = CODE_MAX;
		end
		return c[11:0];
	endfunction

	// ****
	// checking and bus tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		if (a == OFS_SECOND_ORDER) w8 = d[23:0];
		if (a == OFS_FIRST_ORDER) w9 = d[23:0];
		if (a == OFS_CONTROL) w10 = d[23:0];
	endtask

	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("rdata_o", e, rdata_o);
	endtask

	task automatic smp(input int f, input int t);
		@(posedge clk_sys_i);
		sample_i <= {16'(f), 10'(t)};
		sample_vld_i <= 1'b1;
		@(posedge clk_sys_i);
		sample_vld_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
	endtask

	task automatic corner(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c,
		input int f, input int t);
		wr_reg(OFS_SECOND_ORDER, {8'h00, a});
		wr_reg(OFS_FIRST_ORDER, {8'h00, b});
		wr_reg(OFS_CONTROL, {8'h00, c});
		smp(f, t);
	endtask

	// three closed periods guarantee one whole period at the new duty
	task automatic pwm_chk(input logic [11:0] code);
		logic [7:0] c0;
		int n;
		c0 = rx_count;
		n = 0;
		while (8'(rx_count - c0) < 8'd3 && n < 15000) begin
			@(posedge clk_sys_i);
			n++;
		end
		@(negedge clk_sys_i);
		chk("pwm_period", 32'(PWM_PERIOD_CYC), 32'(rx_period));
		chk("pwm_high", 32'(PWM_LO_CYC + ((int'(code) * PWM_SCALE) >>> 12)), 32'(rx_high));
	endtask

	// ****
	// sample pipeline shadow and timeout
	// ****
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (ce_i) begin
			pipe_v <= {pipe_v[4:0], sample_vld_i};
			pipe[0] <= exp_code(sample_i);
			for (int i = 1; i < 6; i++) begin
				pipe[i] <= pipe[i-1];
			end
		end
	end

	always @(negedge clk_sys_i) begin
		if (chk_on && pipe_v[5]) begin
			chk("sent_value_o", 32'(pipe[5]), 32'(sent_value_o));
			chk("output_valid_o", 32'h1, 32'(output_valid_o));
		end
		if (cyc == 90000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// ****
	// main sequence
	// ****
	initial begin
		logic [31:0] d;
		int n;
		rst_i = 1'b1;
		ce_i = 1'b1;
		supply_ok_i = 1'b0;
		sample_i = '0;
		sample_vld_i = 1'b0;
		addr_i = '0;
		wdata_i = '0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		w8 = '0;
		w9 = '0;
		w10 = '0;
		void'($urandom(96));
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rchk(OFS_SECOND_ORDER, 32'h0);
		rchk(OFS_FIRST_ORDER, 32'h0);
		rchk(4'h3, 32'h0);
		rchk(OFS_STATUS, 32'h0);
		@(posedge clk_sys_i);
		supply_ok_i <= 1'b1;
		n = 0;
		while (startup_done_o !== 1'b1 && n < 200) begin
			@(posedge clk_sys_i);
			n++;
		end
		@(negedge clk_sys_i);
		chk("startup_done_o", 32'h1, 32'(startup_done_o));
		chk("output_valid_o", 32'h0, 32'(output_valid_o));
		for (int i = 0; i < 4; i++) begin
			d = $urandom();
			wr_reg(OFS_SECOND_ORDER, d);
			rchk(OFS_SECOND_ORDER, {8'h00, d[23:0]});
			d = $urandom();
			wr_reg(OFS_FIRST_ORDER, d);
			rchk(OFS_FIRST_ORDER, {8'h00, d[23:0]});
		end
		chk_on = 1'b1;
		corner(24'h0, 24'h0, 24'h0, 1000, 0);
		corner(24'h0, 24'h808000, 24'h0, 500, -30);
		corner(24'h0, 24'h00ff7f, 24'h0, 1000, 100);
		corner(24'h0, 24'hff0080, 24'h0, -2000, -40);
		corner(24'hff8000, 24'h0, 24'h0, 3000, 125);
		corner(24'h007fc0, 24'h0, 24'h0, 3000, -40);
		corner(24'h0, 24'h0, 24'h0, 32767, 0);
		corner(24'h0, 24'h0, 24'h0, -32768, 0);
		corner(24'h0, 24'h0, 24'h000640, 0, 0);
		wr_reg(OFS_STATUS, 32'hffffffff);
		rchk(OFS_STATUS, 32'h00640003);
		// back-to-back samples with the clock enable dropping at random
		for (int i = 0; i < 60; i++) begin
			if (i % 10 == 0) begin
				@(posedge clk_sys_i);
				sample_vld_i <= 1'b0;
				ce_i <= 1'b1;
				wr_reg(OFS_SECOND_ORDER, $urandom());
				wr_reg(OFS_FIRST_ORDER, $urandom());
			end
			@(posedge clk_sys_i);
			ce_i <= ($urandom() % 4) != 0;
			sample_vld_i <= 1'b1;
			sample_i <= {16'($urandom()), 10'(($urandom() % 166) - 40)};
		end
		@(posedge clk_sys_i);
		sample_vld_i <= 1'b0;
		ce_i <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		chk_on = 1'b0;
		wr_reg(OFS_SECOND_ORDER, 32'h0);
		wr_reg(OFS_FIRST_ORDER, 32'h0);
		wr_reg(OFS_CONTROL, 32'h1);
		smp(0, 0);
		pwm_chk(12'h800);
		chk("output_valid_o", 32'h0, 32'(output_valid_o));
		smp(32767, 0);
		pwm_chk(12'hfff);
		smp(-32768, 0);
		pwm_chk(12'h000);
		@(posedge clk_sys_i);
		supply_ok_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("startup_done_o", 32'h0, 32'(startup_done_o));
		chk("pwm_o", 32'h0, 32'(pwm_o));
		close_out();
	end
endmodule
